// file: design/scg_pkg.sv
package scg_pkg;

  // Bus geometry
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned SEL_W  = 4;
  localparam int unsigned ID_W   = 5;

  // Register offsets, byte addresses in the control space
  localparam logic [11:0] OFF_SLEEP_GATE  = 12'h114;
  localparam logic [11:0] OFF_IRQ_STATUS  = 12'h1F0;
  localparam logic [11:0] OFF_IRQ_MASK    = 12'h1F4;
  localparam logic [11:0] OFF_FAULT_INFO  = 12'h1F8;
  localparam logic [11:0] OFF_ACTIVE_GATE = 12'h1FC;

  // Gate register reset value and writable bits
  localparam logic [31:0] GATE_RESET    = 32'h00000000;
  localparam logic [31:0] GATE_WRITABLE = 32'h070F1117;

  // Field positions of the gate register
  localparam int unsigned COMPARATOR_A_GATE       = 24;
  localparam int unsigned COMPARATOR_B_GATE       = 25;
  localparam int unsigned COMPARATOR_C_GATE       = 26;
  localparam int unsigned GP_COUNTER_A_GATE       = 16;
  localparam int unsigned GP_COUNTER_B_GATE       = 17;
  localparam int unsigned GP_COUNTER_C_GATE       = 18;
  localparam int unsigned GP_COUNTER_D_GATE       = 19;
  localparam int unsigned TWO_WIRE_BUS_GATE       = 12;
  localparam int unsigned QUADRATURE_ENCODER_GATE = 8;
  localparam int unsigned SYNC_SERIAL_GATE        = 4;
  localparam int unsigned ASYNC_SERIAL_A_GATE     = 0;
  localparam int unsigned ASYNC_SERIAL_B_GATE     = 1;
  localparam int unsigned ASYNC_SERIAL_C_GATE     = 2;

  // Interrupt status and mask layout
  localparam int unsigned IRQ_W     = 2;
  localparam int unsigned IRQ_FAULT = 0;
  localparam int unsigned IRQ_MODE  = 1;
  localparam logic [1:0]  IRQ_RESET = 2'h0;

  // Fault information layout
  localparam int unsigned FI_ID_LSB = 0;
  localparam int unsigned FI_WE     = 8;

  // Power mode as seen by the gating logic
  typedef enum logic [1:0]
  {
    MODE_RUN   = 2'h0,
    MODE_SLEEP = 2'h1,
    MODE_DEEP  = 2'h3
  } scg_mode_t;

endpackage

// file: design/scg_fault_check.sv
`timescale 1ns/1ps
`default_nettype none

module scg_fault_check
(
  input  wire logic                         i_clock,
  input  wire logic                         i_rst,
  input  wire logic [scg_pkg::DATA_W-1:0]   i_enable,
  input  wire logic                         i_req,
  input  wire logic [scg_pkg::ID_W-1:0]     i_id,
  input  wire logic                         i_we,
  output logic                              o_fault,
  output logic      [scg_pkg::ID_W-1:0]     o_fault_id,
  output logic                              o_fault_we
);

  import scg_pkg::*;

  // Access to a peripheral without clock is answered with a fault
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      o_fault <= 1'b0;
    else
      o_fault <= i_req && !i_enable[i_id];
  end

  // Remember the last faulting target for software
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      o_fault_id <= 5'h00;
      o_fault_we <= 1'b0;
    end
    else if (i_req && !i_enable[i_id])
    begin
      o_fault_id <= i_id;
      o_fault_we <= i_we;
    end
  end

endmodule

`default_nettype wire

// file: design/scg_sleep_gate_bank.sv
// Notes on behaviour
// - Each writable gate bit is one peripheral's clock enable.
// - Access to a peripheral whose clock is off raises a bus fault.
// - Sleep gate register at 0x114, resets to zero, all unclocked.
// - Run gates in run, sleep gates in sleep, deep gates in deep sleep; here deep gates also need automatic clock gating, else run gates apply.
// - Sleep gates apply only when automatic clock gating is set.
// - Bits 26..24 gate comparators C, B, A; read-write, reset zero.
// - Bits 19..16 gate counters D..A; read-write, reset zero.
// - Bit 12 gates the two-wire bus unit; read-write, reset zero.
// - Bit 8 gates the quadrature encoder; read-write, reset zero.
// - Bit 4 gates the synchronous serial unit; read-write, reset zero.
// - Bits 2..0 gate async serial C, B, A; read-write, reset zero.
// - Reserved bits read zero and ignore writes; software preserves them.
//
// Our own choice: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none

module scg_sleep_gate_bank
(
  input  wire logic                         I_CLOCK,
  input  wire logic                         I_RST,
  // Wishbone classic slave
  input  wire logic                         I_WB_CYC,
  input  wire logic                         I_WB_STB,
  input  wire logic                         I_WB_WE,
  input  wire logic [scg_pkg::ADDR_W-1:0]   I_WB_ADR,
  input  wire logic [scg_pkg::SEL_W-1:0]    I_WB_SEL,
  input  wire logic [scg_pkg::DATA_W-1:0]   I_WB_DAT,
  output logic      [scg_pkg::DATA_W-1:0]   O_WB_DAT,
  output logic                              O_WB_ACK,
  // System power state and sibling gate registers
  input  wire logic                         I_SYS_SLEEP,
  input  wire logic                         I_SYS_DEEP_SLEEP,
  input  wire logic                         I_AUTO_CLOCK_GATING,
  input  wire logic [scg_pkg::DATA_W-1:0]   I_RUN_CLOCK_GATE_1,
  input  wire logic [scg_pkg::DATA_W-1:0]   I_DEEP_SLEEP_CLOCK_GATE_1,
  // Peripheral access watch
  input  wire logic                         I_PERIPH_REQ,
  input  wire logic [scg_pkg::ID_W-1:0]     I_PERIPH_ID,
  input  wire logic                         I_PERIPH_WE,
  // Outputs
  output logic      [scg_pkg::DATA_W-1:0]   O_CLK_EN,
  output logic                              O_BUS_FAULT,
  output logic                              O_IRQ
);

  import scg_pkg::*;

  // Stored registers
  logic [DATA_W-1:0] sleep_clock_gate_1;
  logic [IRQ_W-1:0]  irq_status;
  logic [IRQ_W-1:0]  irq_mask;
  scg_mode_t         mode;

  // Next values and decode
  logic [DATA_W-1:0] next_sleep_clock_gate_1;
  logic [DATA_W-1:0] next_clk_en;
  logic [DATA_W-1:0] next_rd_dat;
  logic [DATA_W-1:0] byte_mask;
  logic [DATA_W-1:0] fault_info;
  logic [IRQ_W-1:0]  next_irq_status;
  logic [IRQ_W-1:0]  irq_event;
  logic [IRQ_W-1:0]  irq_clear;
  scg_mode_t         next_mode;
  logic              bus_req;
  logic              wr_strobe;
  logic              hit_gate;
  logic              hit_status;
  logic              hit_mask;
  logic              hit_info;
  logic              hit_active;
  logic              fault_pulse;
  logic [ID_W-1:0]   fault_id;
  logic              fault_we;

  // A request is taken once; ack in the following cycle ends it
  assign bus_req   = I_WB_CYC && I_WB_STB && !O_WB_ACK;
  assign wr_strobe = bus_req && I_WB_WE;

  // Word decode; low address bits are ignored inside a word
  assign hit_gate   = I_WB_ADR[11:2] == OFF_SLEEP_GATE[11:2];
  assign hit_status = I_WB_ADR[11:2] == OFF_IRQ_STATUS[11:2];
  assign hit_mask   = I_WB_ADR[11:2] == OFF_IRQ_MASK[11:2];
  assign hit_info   = I_WB_ADR[11:2] == OFF_FAULT_INFO[11:2];
  assign hit_active = I_WB_ADR[11:2] == OFF_ACTIVE_GATE[11:2];

  // Byte enables widened to a bit mask, one lane per generate step
  genvar lane;
  generate
    for (lane = 0; lane < SEL_W; lane++)
    begin : g_lane
      assign byte_mask[lane*8 +: 8] = {8{I_WB_SEL[lane]}};
    end
  endgenerate

  // Merge only enabled bytes and only writable bits
  always_comb
  begin
    next_sleep_clock_gate_1 = sleep_clock_gate_1;
    if (wr_strobe && hit_gate)
    begin
      next_sleep_clock_gate_1 =
        (sleep_clock_gate_1 & ~(byte_mask & GATE_WRITABLE)) |
        (I_WB_DAT & byte_mask & GATE_WRITABLE);
    end
  end

  // Gate register storage; writes store regardless of power mode
  always_ff @(posedge I_CLOCK)
  begin
    if (I_RST)
      sleep_clock_gate_1 <= GATE_RESET;
    else
      sleep_clock_gate_1 <= next_sleep_clock_gate_1;
  end

  // Interrupt mask, low byte lane only
  always_ff @(posedge I_CLOCK)
  begin
    if (I_RST)
      irq_mask <= IRQ_RESET;
    else if (wr_strobe && hit_mask && I_WB_SEL[0])
      irq_mask <= I_WB_DAT[IRQ_W-1:0];
  end

  // Power mode; sleep gating counts only with automatic gating on
  always_comb
  begin
    next_mode = MODE_RUN;
    if (I_AUTO_CLOCK_GATING && I_SYS_DEEP_SLEEP)
      next_mode = MODE_DEEP;
    else if (I_AUTO_CLOCK_GATING && I_SYS_SLEEP)
      next_mode = MODE_SLEEP;
  end

  always_ff @(posedge I_CLOCK)
  begin
    if (I_RST)
      mode <= MODE_RUN;
    else
      mode <= next_mode;
  end

  // Pick the gate set for the current mode; reserved bits never clock
  always_comb
  begin
    unique case (mode)
      MODE_RUN:
        next_clk_en = I_RUN_CLOCK_GATE_1;
      MODE_SLEEP:
        next_clk_en = sleep_clock_gate_1;
      MODE_DEEP:
        next_clk_en = I_DEEP_SLEEP_CLOCK_GATE_1;
      default:
        next_clk_en = GATE_RESET;
    endcase
    next_clk_en = next_clk_en & GATE_WRITABLE;
  end

  // Enables reach the peripherals one cycle after the mode settles.
  // A clock gate cell downstream should sample these to avoid glitches.
  always_ff @(posedge I_CLOCK)
  begin
    if (I_RST)
      O_CLK_EN <= GATE_RESET;
    else
      O_CLK_EN <= next_clk_en;
  end

  // Fault detection against the enables that actually apply
  scg_fault_check u_fault
  (
    .i_clock    (I_CLOCK),
    .i_rst      (I_RST),
    .i_enable   (O_CLK_EN),
    .i_req      (I_PERIPH_REQ),
    .i_id       (I_PERIPH_ID),
    .i_we       (I_PERIPH_WE),
    .o_fault    (fault_pulse),
    .o_fault_id (fault_id),
    .o_fault_we (fault_we)
  );

  assign O_BUS_FAULT = fault_pulse;

  // Events: a fault, and any change of power mode
  assign irq_event[IRQ_FAULT] = fault_pulse;
  assign irq_event[IRQ_MODE]  = mode != next_mode;

  // Write one to clear, low byte lane only
  assign irq_clear = (wr_strobe && hit_status && I_WB_SEL[0]) ?
                     I_WB_DAT[IRQ_W-1:0] : IRQ_RESET;

  // Set wins over a clear landing in the same cycle
  always_comb
  begin
    next_irq_status = (irq_status & ~irq_clear) | irq_event;
  end

  always_ff @(posedge I_CLOCK)
  begin
    if (I_RST)
      irq_status <= IRQ_RESET;
    else
      irq_status <= next_irq_status;
  end

  // Level interrupt from the next status so it tracks without lag
  always_ff @(posedge I_CLOCK)
  begin
    if (I_RST)
      O_IRQ <= 1'b0;
    else
      O_IRQ <= |(next_irq_status & irq_mask);
  end

  // Fault information word
  always_comb
  begin
    fault_info = '0;
    fault_info[FI_ID_LSB +: ID_W] = fault_id;
    fault_info[FI_WE] = fault_we;
  end

  // Read mux; unmapped words read as zero and still acknowledge
  always_comb
  begin
    next_rd_dat = '0;
    if (hit_gate)
      next_rd_dat = sleep_clock_gate_1 & GATE_WRITABLE;
    else if (hit_status)
      next_rd_dat[IRQ_W-1:0] = irq_status;
    else if (hit_mask)
      next_rd_dat[IRQ_W-1:0] = irq_mask;
    else if (hit_info)
      next_rd_dat = fault_info;
    else if (hit_active)
      next_rd_dat = O_CLK_EN;
  end

  // Read data is held only during the ack cycle, zero otherwise
  always_ff @(posedge I_CLOCK)
  begin
    if (I_RST)
      O_WB_DAT <= '0;
    else if (bus_req && !I_WB_WE)
      O_WB_DAT <= next_rd_dat;
    else
      O_WB_DAT <= '0;
  end

  // One-cycle ack, one cycle after the request is seen.
  // Ack drops after one cycle even if the master keeps stb high,
  // which keeps a held request from being taken again in the ack cycle.
  always_ff @(posedge I_CLOCK)
  begin
    if (I_RST)
      O_WB_ACK <= 1'b0;
    else
      O_WB_ACK <= bus_req;
  end

endmodule

`default_nettype wire

// file: testbench/scg_sleep_gate_bank_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module scg_sleep_gate_bank_asserts
(
  input wire logic        I_CLOCK,
  input wire logic        I_RST,
  input wire logic        I_WB_CYC,
  input wire logic        I_WB_STB,
  input wire logic        I_WB_WE,
  input wire logic [11:0] I_WB_ADR,
  input wire logic [31:0] O_WB_DAT,
  input wire logic        O_WB_ACK,
  input wire logic        I_SYS_DEEP_SLEEP,
  input wire logic        I_AUTO_CLOCK_GATING,
  input wire logic [31:0] I_RUN_CLOCK_GATE_1,
  input wire logic [31:0] I_DEEP_SLEEP_CLOCK_GATE_1,
  input wire logic        I_PERIPH_REQ,
  input wire logic [4:0]  I_PERIPH_ID,
  input wire logic [31:0] O_CLK_EN,
  input wire logic        O_BUS_FAULT,
  input wire logic        O_IRQ
);
  localparam logic [31:0] WMASK = 32'h070F1117;
  // One domain; attempts that overlap reset are dropped
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (I_RST);

  property p_ack_rise; I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK;
  endproperty
  a_ack_rise: assert property (p_ack_rise) else $error("ack late");
  property p_ack_once; O_WB_ACK |=> !O_WB_ACK; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held");
  property p_rsv; O_WB_ACK && !I_WB_WE && I_WB_ADR[11:2] == 10'h045
    |-> (O_WB_DAT & ~WMASK) == 32'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit read");
  property p_en_mask; (O_CLK_EN & ~WMASK) == 32'h0; endproperty
  a_en_mask: assert property (p_en_mask) else $error("stray enable");
  // Three stable cycles cover the two-edge mode latency
  property p_run; (!I_AUTO_CLOCK_GATING && $stable(I_RUN_CLOCK_GATE_1))[*3]
    |-> O_CLK_EN == (I_RUN_CLOCK_GATE_1 & WMASK); endproperty
  a_run: assert property (p_run) else $error("run gates wrong");
  property p_deep; (I_AUTO_CLOCK_GATING && I_SYS_DEEP_SLEEP &&
    $stable(I_DEEP_SLEEP_CLOCK_GATE_1))[*3]
    |-> O_CLK_EN == (I_DEEP_SLEEP_CLOCK_GATE_1 & WMASK); endproperty
  a_deep: assert property (p_deep) else $error("deep gates wrong");
  property p_fault; I_PERIPH_REQ && !O_CLK_EN[I_PERIPH_ID] |=> O_BUS_FAULT;
  endproperty
  a_fault: assert property (p_fault) else $error("fault missing");
  property p_nofault; I_PERIPH_REQ && O_CLK_EN[I_PERIPH_ID] |=> !O_BUS_FAULT;
  endproperty
  a_nofault: assert property (p_nofault) else $error("false fault");

  c_fault: cover property (O_BUS_FAULT);
  c_irq: cover property (O_IRQ);
  c_write: cover property (O_WB_ACK && I_WB_WE);
endmodule

bind scg_sleep_gate_bank scg_sleep_gate_bank_asserts u_chk
(
  .I_CLOCK, .I_RST, .I_WB_CYC, .I_WB_STB, .I_WB_WE, .I_WB_ADR, .O_WB_DAT,
  .O_WB_ACK, .I_SYS_DEEP_SLEEP, .I_AUTO_CLOCK_GATING, .I_RUN_CLOCK_GATE_1,
  .I_DEEP_SLEEP_CLOCK_GATE_1, .I_PERIPH_REQ, .I_PERIPH_ID, .O_CLK_EN,
  .O_BUS_FAULT, .O_IRQ
);
`default_nettype wire

// file: testbench/scg_sleep_gate_bank_tb.sv
`timescale 1ns/1ps
`default_nettype none
module scg_sleep_gate_bank_tb;
  import scg_pkg::*;
  // Driven inputs, all defined from time zero
  logic clk = 1'h0, rst = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0;
  logic slp = 1'h0, dsl = 1'h0, agc = 1'h0, preq = 1'h0, pwe = 1'h0;
  logic [11:0] adr = 12'h000;
  logic [3:0]  sel = 4'h0;
  logic [4:0]  pid = 5'h00;
  logic [31:0] wdat = 32'h0, rung = 32'h0, deepg = 32'h0, rd;
  logic [31:0] rdat, clk_en;
  logic        ack, fault, irq;
  int          bad_count = 0, num_checks = 0;

  scg_sleep_gate_bank u_scg_sleep_gate_bank
  (
    .I_CLOCK(clk), .I_RST(rst), .I_WB_CYC(cyc), .I_WB_STB(stb),
    .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat),
    .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_SYS_SLEEP(slp),
    .I_SYS_DEEP_SLEEP(dsl), .I_AUTO_CLOCK_GATING(agc),
    .I_RUN_CLOCK_GATE_1(rung), .I_DEEP_SLEEP_CLOCK_GATE_1(deepg),
    .I_PERIPH_REQ(preq), .I_PERIPH_ID(pid), .I_PERIPH_WE(pwe),
    .O_CLK_EN(clk_en), .O_BUS_FAULT(fault), .O_IRQ(irq)
  );

  // 125 MHz system clock
  always #4 clk = ~clk;

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, exp, input string what);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Classic cycle held until ack; one idle edge after release
  task automatic wb(input logic w, input logic [11:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'h1 && n < 16);
    if (ack === 1'h1)
    begin
      rd = rdat;
      cyc <= 1'h0;
      stb <= 1'h0;
      @(posedge clk);
    end
    else
    begin
      bad_count++;
      tally_and_finish();
    end
  endtask

  // Reserved bits stay zero; lane 0 write touches its byte only
  task automatic t_reset_rsv();
    wb(1'h0, OFF_SLEEP_GATE, 32'h0, 4'hF);
    chk(rd, 32'h00000000, "gate reset");
    wb(1'h1, OFF_SLEEP_GATE, 32'hFFFFFFFF, 4'hF);
    wb(1'h0, OFF_SLEEP_GATE, 32'h0, 4'hF);
    chk(rd, 32'h070F1117, "writable");
    wb(1'h1, OFF_SLEEP_GATE, 32'h0, 4'h1);
    wb(1'h0, OFF_SLEEP_GATE, 32'h0, 4'hF);
    chk(rd, 32'h070F1100, "lane write");
    $display("done reset");
  endtask

  // Each peripheral bit alone, in sleep with auto gating
  task automatic t_fields();
    int bits[13] = '{24, 25, 26, 16, 17, 18, 19, 12, 8, 4, 0, 1, 2};
    agc <= 1'h1;
    slp <= 1'h1;
    foreach (bits[i])
    begin
      wb(1'h1, OFF_SLEEP_GATE, 32'h1 << bits[i], 4'hF);
      chk(clk_en, 32'h1 << bits[i], "enable");
      wb(1'h0, OFF_SLEEP_GATE, 32'h0, 4'hF);
      chk(rd, 32'h1 << bits[i], "readback");
    end
    $display("done fields");
  endtask

  task automatic poke(input logic [4:0] id, input logic w, input logic f);
    preq <= 1'h1;
    pid <= id;
    pwe <= w;
    @(posedge clk);
    preq <= 1'h0;
    @(posedge clk);
    chk({31'h0, fault}, {31'h0, f}, "fault");
  endtask

  // Only bit 2 is clocked now; reserved id 3 must fault too
  task automatic t_fault();
    poke(5'd2, 1'h0, 1'h0);
    poke(5'd0, 1'h0, 1'h1);
    poke(5'd3, 1'h1, 1'h1);
    wb(1'h0, OFF_FAULT_INFO, 32'h0, 4'hF);
    chk(rd, 32'h00000103, "fault info");
    $display("done fault");
  endtask

  task automatic t_modes();
    rung <= 32'hF0F01010;
    deepg <= 32'hF7000001;
    agc <= 1'h0;
    repeat (3) @(posedge clk);
    chk(clk_en, 32'h00001010, "no auto");
    wb(1'h1, OFF_SLEEP_GATE, 32'h00000100, 4'hF);
    chk(clk_en, 32'h00001010, "stored only");
    agc <= 1'h1;
    repeat (3) @(posedge clk);
    chk(clk_en, 32'h00000100, "sleep");
    dsl <= 1'h1;
    repeat (3) @(posedge clk);
    chk(clk_en, 32'h07000001, "deep");
    slp <= 1'h0;
    dsl <= 1'h0;
    repeat (3) @(posedge clk);
    chk(clk_en, 32'h00001010, "run");
    wb(1'h0, OFF_ACTIVE_GATE, 32'h0, 4'hF);
    chk(rd, 32'h00001010, "active");
    $display("done modes");
  endtask

  // Sticky status, mask, one-to-clear, unmapped read
  task automatic t_irq();
    chk({31'h0, irq}, 32'h0, "irq masked");
    wb(1'h0, OFF_IRQ_STATUS, 32'h0, 4'hF);
    chk(rd, 32'h00000003, "status");
    wb(1'h1, OFF_IRQ_MASK, 32'h00000001, 4'hF);
    chk({31'h0, irq}, 32'h1, "irq up");
    wb(1'h1, OFF_IRQ_STATUS, 32'h00000003, 4'hF);
    chk({31'h0, irq}, 32'h0, "irq clear");
    wb(1'h0, 12'h200, 32'h0, 4'hF);
    chk(rd, 32'h0, "unmapped");
    $display("done irq");
  endtask

  // Reset for four edges, then the scenarios in turn
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    t_reset_rsv();
    t_fields();
    t_fault();
    t_modes();
    t_irq();
    tally_and_finish();
  end
endmodule
`default_nettype wire
